// ---- hdl/afs_pkg.sv ----
// Purpose: Constants and types for the audio FIFO status block
// Assumes: APB slave, 32-bit data, one clock core_clk
// Notes:   Offsets of the software registers are local choices
package afs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] AFS_OFF_STATUS    = 12'h000;
    localparam logic [11:0] AFS_OFF_THRESHOLD = 12'h004;
    localparam logic [11:0] AFS_OFF_IRQ_STAT  = 12'h008;
    localparam logic [11:0] AFS_OFF_IRQ_MASK  = 12'h00C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int AFS_RX_LVL_LSB  = 24;
    localparam int AFS_TX_LVL_LSB  = 8;
    localparam int AFS_RX_OVR_BIT  = 6;
    localparam int AFS_TX_UND_BIT  = 5;
    localparam int AFS_RX_SRQ_BIT  = 4;
    localparam int AFS_TX_SRQ_BIT  = 3;
    localparam int AFS_RX_THR_LSB  = 8;
    localparam int AFS_TX_THR_LSB  = 0;
    localparam int AFS_LVL_W       = 6;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [5:0] AFS_DEPTH       = 6'h20;
    localparam logic [5:0] AFS_RX_THR_RST  = 6'h10;
    localparam logic [5:0] AFS_TX_THR_RST  = 6'h10;
    localparam logic [3:0] AFS_IRQ_RST     = 4'h0;

    // Interrupt status bit order: rx overrun, tx underrun, rx srq, tx srq
    typedef struct packed {
        logic rx_ovr;
        logic tx_und;
        logic rx_srq;
        logic tx_srq;
    } afs_events_t;

    typedef struct packed {
        logic       push;
        logic       pop;
    } afs_fifo_ev_t;

endpackage : afs_pkg

// ---- hdl/afs_level.sv ----
// Purpose: Occupancy counter of one sample FIFO with error detect
// Assumes: FIFO storage elsewhere; push and pop are one-cycle strobes
// Notes:   Push into full and pop from empty do not move the count
`timescale 1ns/1ps
module afs_level
    import afs_pkg::*;
#(
    parameter logic [5:0] DEPTH = AFS_DEPTH
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    // FIFO strobes
    input  wire afs_fifo_ev_t ev,
    // Results
    output logic [5:0]        level,
    output logic              overflow,
    output logic              underflow
);

    typedef struct packed {
        logic [5:0] level;
        logic       overflow;
        logic       underflow;
    } afs_lvl_state_t;

    afs_lvl_state_t state;
    afs_lvl_state_t next_state;

    always_comb begin
        next_state           = state;
        next_state.overflow  = ev.push && !ev.pop && (state.level == DEPTH);
        next_state.underflow = ev.pop && !ev.push && (state.level == 6'h00);
        if (ev.push && !ev.pop && state.level != DEPTH) begin
            next_state.level = state.level + 6'h01;
        end else if (ev.pop && !ev.push && state.level != 6'h00) begin
            next_state.level = state.level - 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level     = state.level;
    assign overflow  = state.overflow;
    assign underflow = state.underflow;

endmodule // afs_level

// ---- hdl/afs_top.sv ----
// Purpose: FIFO status register, error flags and service requests
// Assumes: APB slave; FIFO strobes come from core_clk logic
// Notes:   Status, threshold, interrupt status and mask registers
`timescale 1ns/1ps
module afs_top
    import afs_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // FIFO strobes
    input  wire afs_fifo_ev_t rx_ev,
    input  wire afs_fifo_ev_t tx_ev,
    // Requests
    output logic              rx_service_request,
    output logic              tx_service_request,
    output logic              irq
);

    // ------------------------------------------------------------
    // Level counters
    // ------------------------------------------------------------
    logic [5:0] rx_lvl;
    logic [5:0] tx_lvl;
    logic       rx_full_push;
    logic       tx_empty_pop;

    afs_level #(.DEPTH(AFS_DEPTH)) u_rx_level (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .ev        (rx_ev),
        .level     (rx_lvl),
        .overflow  (rx_full_push),
        .underflow ()
    );

    afs_level #(.DEPTH(AFS_DEPTH)) u_tx_level (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .ev        (tx_ev),
        .level     (tx_lvl),
        .overflow  (),
        .underflow (tx_empty_pop)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0]  rx_thr;
        logic [5:0]  tx_thr;
        logic        rx_overrun_flag;
        logic        tx_underrun_flag;
        afs_events_t irq_stat;
        afs_events_t irq_mask;
        logic        rx_srq;
        logic        tx_srq;
        logic        irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } afs_state_t;

    afs_state_t state;
    afs_state_t next_state;

    logic        access;
    logic        wr;
    logic [31:0] status_word;
    logic        rx_srq_now;
    logic        tx_srq_now;
    afs_events_t ev_now;

    assign access = psel && penable && !state.pready;
    assign wr     = access && pwrite;

    // Requests use the counter value of the cycle after the strobe
    assign rx_srq_now = (rx_lvl >= state.rx_thr);
    assign tx_srq_now = (tx_lvl <= state.tx_thr);

    assign ev_now = '{rx_ovr: rx_full_push, tx_und: tx_empty_pop,
                      rx_srq: rx_srq_now && !state.rx_srq,
                      tx_srq: tx_srq_now && !state.tx_srq};

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[AFS_RX_LVL_LSB +: AFS_LVL_W] = rx_lvl;
        status_word[AFS_TX_LVL_LSB +: AFS_LVL_W] = tx_lvl;
        status_word[AFS_RX_OVR_BIT] = state.rx_overrun_flag;
        status_word[AFS_TX_UND_BIT] = state.tx_underrun_flag;
        status_word[AFS_RX_SRQ_BIT] = rx_srq_now;
        status_word[AFS_TX_SRQ_BIT] = tx_srq_now;
    end

    always_comb begin
        next_state         = state;
        next_state.pready  = access;
        next_state.pslverr = 1'b0;
        next_state.rx_srq  = rx_srq_now;
        next_state.tx_srq  = tx_srq_now;

        // Flag clears by writing zero; a same-cycle event wins
        if (wr && paddr == AFS_OFF_STATUS) begin
            if (!pwdata[AFS_RX_OVR_BIT]) begin
                next_state.rx_overrun_flag = 1'b0;
            end
            if (!pwdata[AFS_TX_UND_BIT]) begin
                next_state.tx_underrun_flag = 1'b0;
            end
        end
        if (rx_full_push) begin
            next_state.rx_overrun_flag = 1'b1;
        end
        if (tx_empty_pop) begin
            next_state.tx_underrun_flag = 1'b1;
        end

        if (wr && paddr == AFS_OFF_THRESHOLD) begin
            next_state.rx_thr = pwdata[AFS_RX_THR_LSB +: AFS_LVL_W];
            next_state.tx_thr = pwdata[AFS_TX_THR_LSB +: AFS_LVL_W];
        end
        if (wr && paddr == AFS_OFF_IRQ_STAT) begin
            next_state.irq_stat = state.irq_stat & ~afs_events_t'(pwdata[3:0]);
        end
        next_state.irq_stat = next_state.irq_stat | ev_now;
        if (wr && paddr == AFS_OFF_IRQ_MASK) begin
            next_state.irq_mask = afs_events_t'(pwdata[3:0]);
        end
        next_state.irq = |(next_state.irq_stat & next_state.irq_mask);

        next_state.prdata = 32'h0000_0000;
        if (access && !pwrite) begin
            if (paddr == AFS_OFF_STATUS) begin
                next_state.prdata = status_word;
            end else if (paddr == AFS_OFF_THRESHOLD) begin
                next_state.prdata[AFS_RX_THR_LSB +: AFS_LVL_W] = state.rx_thr;
                next_state.prdata[AFS_TX_THR_LSB +: AFS_LVL_W] = state.tx_thr;
            end else if (paddr == AFS_OFF_IRQ_STAT) begin
                next_state.prdata[3:0] = state.irq_stat;
            end else if (paddr == AFS_OFF_IRQ_MASK) begin
                next_state.prdata[3:0] = state.irq_mask;
            end else begin
                next_state.pslverr = 1'b1;
            end
        end else if (access) begin
            if (paddr != AFS_OFF_STATUS && paddr != AFS_OFF_THRESHOLD &&
                paddr != AFS_OFF_IRQ_STAT && paddr != AFS_OFF_IRQ_MASK) begin
                next_state.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state          <= '0;
            state.rx_thr   <= AFS_RX_THR_RST;
            state.tx_thr   <= AFS_TX_THR_RST;
            state.irq_mask <= afs_events_t'(AFS_IRQ_RST);
        end else begin
            state <= next_state;
        end
    end

    assign prdata             = state.prdata;
    assign pready             = state.pready;
    assign pslverr            = state.pslverr;
    assign rx_service_request = state.rx_srq;
    assign tx_service_request = state.tx_srq;
    assign irq                = state.irq;

endmodule // afs_top

// ---- tb/afs_props.sv ----
// Purpose: Port properties of the audio FIFO status block
// Assumes: Request moves follow a strobe or a threshold write
// Notes:   Bound to afs_top
`timescale 1ns/1ps
module afs_props
    import afs_pkg::*;
(
    input wire logic         core_clk,
    input wire logic         arst_n,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [11:0]  paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire afs_fifo_ev_t rx_ev,
    input wire afs_fifo_ev_t tx_ev,
    input wire logic         rx_service_request,
    input wire logic         tx_service_request,
    input wire logic         irq
);
    // Masks the request rise that follows reset release
    logic [1:0] up;
    // Threshold write in its access cycle; it may move either request
    logic       thr_wr;
    assign thr_wr = psel && penable && pwrite && paddr == AFS_OFF_THRESHOLD;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            up <= 2'h0;
        else if (up != 2'h3)
            up <= up + 2'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_stat_rd;
        pready && !pwrite && paddr == AFS_OFF_STATUS && !pslverr;
    endsequence
    AST_RX_LVL: assert property (s_stat_rd |-> prdata[29:24] <= AFS_DEPTH)
        else $error("rx level above depth");
    AST_TX_LVL: assert property (s_stat_rd |-> prdata[13:8] <= AFS_DEPTH)
        else $error("tx level above depth");
    AST_RSV_HI: assert property (s_stat_rd |-> prdata[31:30] == 2'h0 && prdata[23:14] == 10'h0)
        else $error("upper reserved bits set");
    AST_RSV_LO: assert property (s_stat_rd |-> prdata[7] == 1'b0 && prdata[2:0] == 3'h0)
        else $error("lower reserved bits set");
    AST_RX_SRQ_UP: assert property (up == 2'h3 && $rose(rx_service_request) |-> $past(rx_ev.push, 2) || $past(thr_wr, 2))
        else $error("rx request rose without push");
    AST_RX_SRQ_DN: assert property (up == 2'h3 && $fell(rx_service_request) |-> $past(rx_ev.pop, 2) || $past(thr_wr, 2))
        else $error("rx request fell without pop");
    AST_TX_SRQ_UP: assert property (up == 2'h3 && $rose(tx_service_request) |-> $past(tx_ev.pop, 2) || $past(thr_wr, 2))
        else $error("tx request rose without pop");
    AST_TX_SRQ_DN: assert property (up == 2'h3 && $fell(tx_service_request) |-> $past(tx_ev.push, 2) || $past(thr_wr, 2))
        else $error("tx request fell without push");
endmodule // afs_props

bind afs_top afs_props u_props (
    .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_ev(rx_ev), .tx_ev(tx_ev),
    .rx_service_request(rx_service_request), .tx_service_request(tx_service_request), .irq(irq));

// ---- tb/afs_fifo_model.sv ----
// Purpose: Sample FIFO side that issues push and pop strobes
// Assumes: One strobe per call, idle cycle between calls
// Notes:   Called hierarchically from the testbench
`timescale 1ns/1ps
module afs_fifo_model
    import afs_pkg::*;
(
    input  wire logic   core_clk,
    output afs_fifo_ev_t ev
);
    initial ev = '0;
    task automatic strobe(input logic push, input logic pop);
        @(posedge core_clk);
        ev <= {push, pop};
        @(posedge core_clk);
        ev <= '0;
    endtask
endmodule // afs_fifo_model

// ---- tb/audio_fifo_status_test.sv ----
// Purpose: Self-checking bench of the audio FIFO status block
// Assumes: Thresholds at reset value 0x10 until the last scenarios
// Notes:   APB master tasks with bounded waits
`timescale 1ns/1ps
module audio_fifo_status_test;
    import afs_pkg::*;
    logic         core_clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready, pslverr, rx_srq, tx_srq, irq, err;
    logic [31:0]  rd;
    afs_fifo_ev_t rx_ev, tx_ev;
    int           mismatches = 0;
    int           num_checks = 0;

    always #2 core_clk = ~core_clk;

    afs_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_ev(rx_ev),
        .tx_ev(tx_ev), .rx_service_request(rx_srq), .tx_service_request(tx_srq), .irq(irq));
    afs_fifo_model u_rx (.core_clk(core_clk), .ev(rx_ev));
    afs_fifo_model u_tx (.core_clk(core_clk), .ev(tx_ev));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge core_clk);
        if (pready !== 1'b1) begin
            mismatches++;
            print_verdict;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic settle;
        repeat (3) @(posedge core_clk);
    endtask

    initial begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        rdc("status", AFS_OFF_STATUS, 32'h0000_0008);
        rdc("threshold", AFS_OFF_THRESHOLD, 32'h0000_1010);
        rdc("unmapped", 12'h010, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        u_tx.strobe(1'b0, 1'b1);
        settle;
        rdc("underrun", AFS_OFF_STATUS, 32'h0000_0028);
        apb(1'b1, AFS_OFF_STATUS, 32'hFFFF_FFFF);
        rdc("write one", AFS_OFF_STATUS, 32'h0000_0028);
        apb(1'b1, AFS_OFF_STATUS, 32'h0);
        rdc("write zero", AFS_OFF_STATUS, 32'h0000_0008);
        repeat (33) u_rx.strobe(1'b1, 1'b0);
        settle;
        rdc("overrun", AFS_OFF_STATUS, 32'h2000_0058);
        repeat (16) u_rx.strobe(1'b0, 1'b1);
        settle;
        chk("rx srq at thr", 32'h1, {31'h0, rx_srq});
        u_rx.strobe(1'b0, 1'b1);
        settle;
        chk("rx srq below", 32'h0, {31'h0, rx_srq});
        repeat (16) u_tx.strobe(1'b1, 1'b0);
        settle;
        chk("tx srq at thr", 32'h1, {31'h0, tx_srq});
        u_tx.strobe(1'b1, 1'b0);
        settle;
        chk("tx srq above", 32'h0, {31'h0, tx_srq});
        rdc("levels", AFS_OFF_STATUS, 32'h0F00_1140);
        apb(1'b1, AFS_OFF_IRQ_STAT, 32'hF);
        apb(1'b1, AFS_OFF_IRQ_MASK, 32'h4);
        rdc("irq stat", AFS_OFF_IRQ_STAT, 32'h0);
        repeat (18) u_rx.strobe(1'b1, 1'b0);
        settle;
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, AFS_OFF_IRQ_MASK, 32'h8);
        settle;
        chk("irq raised", 32'h1, {31'h0, irq});
        rdc("irq events", AFS_OFF_IRQ_STAT, 32'hA);
        apb(1'b1, AFS_OFF_IRQ_STAT, 32'hA);
        settle;
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, AFS_OFF_THRESHOLD, 32'h0000_2111);
        settle;
        chk("rx srq thr moved", 32'h0, {31'h0, rx_srq});
        chk("tx srq thr moved", 32'h1, {31'h0, tx_srq});
        rdc("threshold set", AFS_OFF_THRESHOLD, 32'h0000_2111);
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        rdc("status after reset", AFS_OFF_STATUS, 32'h0000_0008);
        rdc("threshold after reset", AFS_OFF_THRESHOLD, 32'h0000_1010);
        print_verdict;
    end
endmodule // audio_fifo_status_test
